// ### verilog/skip_exec_defs.svh
// constants for the conditional skip execution block
`ifndef SKIP_EXEC_DEFS_SVH
`define SKIP_EXEC_DEFS_SVH
`define DATA_W 8
`define ADDR_W 8
`define MEM_DEPTH 256
`define BIT_SEL_W 3
`define ACC_RESET 8'h00
`define INC_ONE 8'h01
`define ZERO_BYTE 8'h00
`define SKIP_CYCLES 3
`define PLAIN_CYCLES 2
`endif

// ### verilog/skip_exec_pkg.sv
// types for the conditional skip execution block
`include "skip_exec_defs.svh"
package skip_exec_pkg;
   typedef enum logic [1:0] {
      OP_NONE,
      OP_INC_MEM_SKIP_IF_ZERO,
      OP_INC_TO_ACC_SKIP_IF_ZERO,
      OP_SKIP_IF_BIT_SET
   } skip_op_t;
   typedef enum {
      ST_IDLE,
      ST_READ,
      ST_EXEC,
      ST_DUMMY
   } exec_state_t;
endpackage

// ### verilog/data_mem.sv
// data memory with registered read data and one write port
`timescale 1ns/1ns
`include "skip_exec_defs.svh"
module data_mem (
   input wire logic clock,
   input wire logic [`ADDR_W-1:0] readAddr,
   output logic [`DATA_W-1:0] readData,
   input wire logic writeEn,
   input wire logic [`ADDR_W-1:0] writeAddr,
   input wire logic [`DATA_W-1:0] writeData
);
   logic [`DATA_W-1:0] store [`MEM_DEPTH];

   // write port
   always_ff @(posedge clock) begin
      if (writeEn) begin
         store[writeAddr] <= writeData;
      end
   end

   // registered read port
   always_ff @(posedge clock) begin
      readData <= store[readAddr];
   end
endmodule

// ### verilog/skip_on_zero_instr_exec.sv
// executes the three conditional skip instructions against a local data memory
`timescale 1ns/1ns
`include "skip_exec_defs.svh"
// Contract
// - increment-memory op adds one, writes byte back, skips when sum is zero
// - nonzero incremented result means no skip, next instruction runs
// - accumulator variant loads sum into accumulator, memory untouched, skip on zero
// - bit-test op skips when the selected memory bit is one
// - tested bit zero means no skip, sequential instruction runs
// - a taken skip adds a dummy cycle, making three cycles total
module skip_on_zero_instr_exec
   import skip_exec_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic start,
   input wire skip_op_t opcode,
   input wire logic [`ADDR_W-1:0] memAddr,
   input wire logic [`BIT_SEL_W-1:0] bitSel,
   input wire logic loadEn,
   input wire logic [`ADDR_W-1:0] loadAddr,
   input wire logic [`DATA_W-1:0] loadData,
   output logic busy,
   output logic done,
   output logic skipTaken,
   output logic dummyCycle,
   output logic [`DATA_W-1:0] accumulator,
   output logic [3:0] statusFlags,
   output logic [`DATA_W-1:0] memRead
);
   exec_state_t state;
   skip_op_t curOp;
   logic [`ADDR_W-1:0] curAddr;
   logic [`BIT_SEL_W-1:0] curBit;
   logic [`DATA_W-1:0] memData;
   logic [`DATA_W-1:0] incResult;
   logic takeSkip;
   logic memWriteEn;
   logic [`ADDR_W-1:0] memWriteAddr;
   logic [`DATA_W-1:0] memWriteData;
   logic [`ADDR_W-1:0] memReadAddr;

   // idle reads follow the request address so the external view works too
   assign memReadAddr = (state == ST_IDLE) ? memAddr : curAddr;

   // loader port wins only while idle; execution owns the memory otherwise
   always_comb begin
      memWriteEn = 1'b0;
      memWriteAddr = curAddr;
      memWriteData = incResult;
      if (state == ST_EXEC && curOp == OP_INC_MEM_SKIP_IF_ZERO) begin
         memWriteEn = 1'b1;
      end else if (state == ST_IDLE && loadEn) begin
         memWriteEn = 1'b1;
         memWriteAddr = loadAddr;
         memWriteData = loadData;
      end
   end

   data_mem u_mem (
      .clock(clock),
      .readAddr(memReadAddr),
      .readData(memData),
      .writeEn(memWriteEn),
      .writeAddr(memWriteAddr),
      .writeData(memWriteData)
   );

   // increment and skip decision
   assign incResult = memData + `INC_ONE;
   always_comb begin
      case (curOp)
         OP_INC_MEM_SKIP_IF_ZERO: takeSkip = (incResult == `ZERO_BYTE);
         OP_INC_TO_ACC_SKIP_IF_ZERO: takeSkip = (incResult == `ZERO_BYTE);
         OP_SKIP_IF_BIT_SET: takeSkip = memData[curBit];
         default: takeSkip = 1'b0;
      endcase
   end

   // sequencer: read, execute, optional dummy cycle
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: if (start && opcode != OP_NONE) state <= ST_READ;
            ST_READ: state <= ST_EXEC;
            ST_EXEC: state <= takeSkip ? ST_DUMMY : ST_IDLE;
            ST_DUMMY: state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // capture the request
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         curOp <= OP_NONE;
         curAddr <= '0;
         curBit <= '0;
      end else if (state == ST_IDLE && start) begin
         curOp <= opcode;
         curAddr <= memAddr;
         curBit <= bitSel;
      end
   end

   // accumulator only written by the accumulator variant
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         accumulator <= `ACC_RESET;
      end else if (state == ST_EXEC && curOp == OP_INC_TO_ACC_SKIP_IF_ZERO) begin
         accumulator <= incResult;
      end
   end

   // completion and skip report
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         done <= 1'b0;
         skipTaken <= 1'b0;
      end else begin
         done <= (state == ST_EXEC && !takeSkip) || state == ST_DUMMY;
         if (state == ST_EXEC) begin
            skipTaken <= takeSkip;
         end
      end
   end

   // registered view of memory for the core
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         memRead <= `ZERO_BYTE;
      end else begin
         memRead <= memData;
      end
   end

   // status flags are never modified by these instructions
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         statusFlags <= 4'h0;
      end else begin
         statusFlags <= statusFlags;
      end
   end

   assign busy = (state != ST_IDLE);
   assign dummyCycle = (state == ST_DUMMY);

   // a skip lasts read, execute and dummy: three cycles
   skip_three_a: assert property (@(posedge clock) disable iff (!rst_b)
      (state == ST_EXEC && takeSkip) |=> dummyCycle ##1 (done && !busy))
      else $error("skip did not take three cycles");

   no_skip_two_a: assert property (@(posedge clock) disable iff (!rst_b)
      (state == ST_EXEC && !takeSkip) |=> (done && !dummyCycle && !busy))
      else $error("non-skip took a dummy cycle");

   mem_write_a: assert property (@(posedge clock) disable iff (!rst_b)
      (state == ST_EXEC && curOp == OP_INC_MEM_SKIP_IF_ZERO)
      |-> (memWriteEn && memWriteData == memData + `INC_ONE))
      else $error("increment not written back");

   acc_load_a: assert property (@(posedge clock) disable iff (!rst_b)
      (state == ST_EXEC && curOp == OP_INC_TO_ACC_SKIP_IF_ZERO)
      |=> (accumulator == $past(memData) + `INC_ONE))
      else $error("accumulator not loaded");

   acc_nomem_a: assert property (@(posedge clock) disable iff (!rst_b)
      (state != ST_IDLE && curOp != OP_INC_MEM_SKIP_IF_ZERO) |-> !memWriteEn)
      else $error("memory written by wrong op");

   bit_skip_a: assert property (@(posedge clock) disable iff (!rst_b)
      (state == ST_EXEC && curOp == OP_SKIP_IF_BIT_SET && memData[curBit]) |=> dummyCycle)
      else $error("bit set did not skip");

   bit_noskip_a: assert property (@(posedge clock) disable iff (!rst_b)
      (state == ST_EXEC && curOp == OP_SKIP_IF_BIT_SET && !memData[curBit])
      |=> (!dummyCycle && !skipTaken))
      else $error("bit clear skipped");

   flags_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
      busy |=> $stable(statusFlags))
      else $error("status flags changed");

   // an accepted request shows busy in the next cycle with no stale done
   take_busy_a: assert property (@(posedge clock) disable iff (!rst_b)
      (state == ST_IDLE && start && opcode != OP_NONE) |=> (busy && !done))
      else $error("request not accepted");

   // the read cycle always moves on to execute
   read_exec_a: assert property (@(posedge clock) disable iff (!rst_b)
      (state == ST_READ) |=> (busy && !dummyCycle && !done))
      else $error("read cycle not followed by execute");

   // an all-ones byte wraps to zero, so the memory variant must skip
   zero_sum_skip_a: assert property (@(posedge clock) disable iff (!rst_b)
      (state == ST_EXEC && curOp == OP_INC_MEM_SKIP_IF_ZERO && (&memData))
      |=> (skipTaken && dummyCycle))
      else $error("wrapped sum did not skip");

   // any other byte gives a nonzero sum and no skip
   sum_noskip_a: assert property (@(posedge clock) disable iff (!rst_b)
      (state == ST_EXEC && curOp == OP_INC_MEM_SKIP_IF_ZERO && !(&memData))
      |=> (!skipTaken && !dummyCycle))
      else $error("nonzero sum skipped");

   // the sum goes back to the operand address captured at the start
   write_addr_a: assert property (@(posedge clock) disable iff (!rst_b)
      (state == ST_EXEC && curOp == OP_INC_MEM_SKIP_IF_ZERO) |-> (memWriteAddr == curAddr))
      else $error("sum written to wrong address");

   // accumulator variant on an all-ones byte loads zero and skips
   acc_zero_skip_a: assert property (@(posedge clock) disable iff (!rst_b)
      (state == ST_EXEC && curOp == OP_INC_TO_ACC_SKIP_IF_ZERO && (&memData))
      |=> (skipTaken && dummyCycle && accumulator == `ZERO_BYTE))
      else $error("wrapped accumulator sum did not skip");

   // the accumulator moves only at the end of an accumulator variant execute
   acc_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
      !(state == ST_EXEC && curOp == OP_INC_TO_ACC_SKIP_IF_ZERO) |=> $stable(accumulator))
      else $error("accumulator changed by another op");

   // done is a single-cycle pulse
   done_pulse_a: assert property (@(posedge clock) disable iff (!rst_b)
      done |=> !done)
      else $error("done held for more than one cycle");

   // flags stay at their reset value throughout
   flags_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
      statusFlags == 4'h0)
      else $error("status flags left reset value");
endmodule

// ### testbench/skip_on_zero_instr_exec_test.sv
// self-checking bench for the conditional skip execution block
`timescale 1ns/1ns
`include "skip_exec_defs.svh"
module skip_on_zero_instr_exec_test import skip_exec_pkg::*;;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic start = 1'b0;
   skip_op_t opcode = OP_NONE;
   logic [7:0] memAddr = 8'h00;
   logic [2:0] bitSel = 3'h0;
   logic loadEn = 1'b0;
   logic [7:0] loadAddr = 8'h00;
   logic [7:0] loadData = 8'h00;
   logic busy, done, skipTaken, dummyCycle;
   logic [7:0] accumulator, memRead;
   logic [3:0] statusFlags;
   int failCount = 0;
   int comparisons = 0;
   skip_on_zero_instr_exec u_skip_on_zero_instr_exec (.clock(clock), .rst_b(rst_b),
      .start(start), .opcode(opcode), .memAddr(memAddr), .bitSel(bitSel), .loadEn(loadEn),
      .loadAddr(loadAddr), .loadData(loadData), .busy(busy), .done(done),
      .skipTaken(skipTaken), .dummyCycle(dummyCycle), .accumulator(accumulator),
      .statusFlags(statusFlags), .memRead(memRead));
   // 10 MHz clock
   always #50 clock = ~clock;
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, failCount);
      if (failCount == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         failCount++;
         $display("ERROR t=%0t %s", $time, msg);
      end
   endtask
   // preload one byte while idle
   task automatic load(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      loadEn <= 1'b1;
      loadAddr <= a;
      loadData <= d;
      @(posedge clock);
      loadEn <= 1'b0;
   endtask
   // idle read through the registered read path
   task automatic peek(input logic [7:0] a, output logic [7:0] v);
      @(posedge clock);
      memAddr <= a;
      repeat (3) @(posedge clock);
      #1;
      v = memRead;
   endtask
   // one instruction, timed from its start pulse to done
   task automatic run(input skip_op_t op, input logic [7:0] a, input logic [2:0] b,
      input logic sk);
      int n;
      int nb;
      logic dum;
      n = 0;
      nb = 0;
      dum = 1'b0;
      @(posedge clock);
      start <= 1'b1;
      opcode <= op;
      memAddr <= a;
      bitSel <= b;
      // always wait one edge first: done of the last run may still show here
      while (n < 8 && (n == 0 || done !== 1'b1)) begin
         @(posedge clock);
         start <= 1'b0;
         #1;
         n++;
         if (dummyCycle === 1'b1) dum = 1'b1;
         if (busy === 1'b1) nb++;
      end
      if (done !== 1'b1) begin
         chk(1'b0, "done timeout");
         conclude();
      end else begin
         chk(n == (sk ? `SKIP_CYCLES + 1 : `PLAIN_CYCLES + 1), "cycle count");
         chk(nb == (sk ? `SKIP_CYCLES : `PLAIN_CYCLES), "busy cycles");
         chk(dum === sk, "dummy cycle");
         chk(statusFlags === 4'h0, "flags changed");
      end
   endtask
   task automatic test_inc_mem();
      logic [7:0] v;
      load(8'h10, 8'hff);
      run(OP_INC_MEM_SKIP_IF_ZERO, 8'h10, 3'h0, 1'b1);
      chk(skipTaken === 1'b1, "zero sum not skipped");
      peek(8'h10, v);
      chk(v === 8'h00, "sum not written");
      load(8'h11, 8'h41);
      run(OP_INC_MEM_SKIP_IF_ZERO, 8'h11, 3'h0, 1'b0);
      chk(skipTaken === 1'b0, "nonzero sum skipped");
      peek(8'h11, v);
      chk(v === 8'h42, "sum wrong");
      $display("test inc_mem finished");
   endtask
   task automatic test_inc_acc();
      logic [7:0] v;
      load(8'h20, 8'h7e);
      run(OP_INC_TO_ACC_SKIP_IF_ZERO, 8'h20, 3'h0, 1'b0);
      chk(accumulator === 8'h7f && skipTaken === 1'b0, "acc nonzero case");
      load(8'h21, 8'hff);
      run(OP_INC_TO_ACC_SKIP_IF_ZERO, 8'h21, 3'h0, 1'b1);
      chk(accumulator === 8'h00 && skipTaken === 1'b1, "acc zero case");
      peek(8'h21, v);
      chk(v === 8'hff, "memory changed");
      $display("test inc_acc finished");
   endtask
   task automatic test_bits();
      logic [7:0] v;
      logic [7:0] pat;
      pat = 8'ha5;
      load(8'h30, pat);
      for (int i = 0; i < 8; i++) begin
         run(OP_SKIP_IF_BIT_SET, 8'h30, 3'(i), pat[i]);
         chk(skipTaken === pat[i], "bit test result");
      end
      peek(8'h30, v);
      chk(v === pat, "bit test wrote memory");
      $display("test bits finished");
   endtask
   // outputs as left by the first reset
   task automatic test_reset();
      #1;
      chk(busy === 1'b0 && done === 1'b0 && dummyCycle === 1'b0, "busy after reset");
      chk(skipTaken === 1'b0 && accumulator === `ACC_RESET, "result after reset");
      chk(statusFlags === 4'h0 && memRead === `ZERO_BYTE, "flags after reset");
      $display("test reset finished");
   endtask
   // empty opcode is ignored; a reset in mid-instruction abandons it
   task automatic test_refused();
      int n;
      n = 0;
      @(posedge clock);
      start <= 1'b1;
      opcode <= OP_NONE;
      @(posedge clock);
      start <= 1'b0;
      repeat (3) begin
         @(posedge clock);
         #1;
         if (busy !== 1'b0 || done !== 1'b0) n++;
      end
      chk(n == 0, "empty opcode started work");
      @(posedge clock);
      start <= 1'b1;
      opcode <= OP_INC_TO_ACC_SKIP_IF_ZERO;
      memAddr <= 8'h20;
      @(posedge clock);
      start <= 1'b0;
      rst_b <= 1'b0;
      @(posedge clock);
      rst_b <= 1'b1;
      #1;
      chk(busy === 1'b0 && done === 1'b0 && skipTaken === 1'b0, "reset left work");
      run(OP_SKIP_IF_BIT_SET, 8'h30, 3'h0, 1'b1);
      chk(skipTaken === 1'b1, "no skip after reset");
      $display("test refused finished");
   endtask
   initial begin
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
      test_reset();
      test_inc_mem();
      test_inc_acc();
      test_bits();
      test_refused();
      conclude();
   end
endmodule
